// >>> design/adc_poller.sv
// Periodic ADC conversion requests with timeout detection
`timescale 1ns/1ns
`include "cart_ctl_regs.svh"

module adc_poller #(
   parameter int POLL_CYC = `POLL_CYC
) (
   input  wire logic       ref_clk,
   input  wire logic       reset,
   input  wire logic       enable,
   input  wire logic       adcDone,
   input  wire logic [9:0] adcData,
   output logic            convStart,
   output logic            sampleValid,
   output logic [9:0]      sample,
   output logic            fault
);

   cart_ctl_pkg::poll_state_t st;
   cart_ctl_pkg::poll_state_t next_st;
   logic tick;

   // Divider tick; first poll comes right after enable
   assign tick = (st.div == 16'h0000);

   always_comb begin
      next_st       = st;
      next_st.in1   = {adcDone, adcData};
      next_st.in2   = st.in1;
      next_st.start = 1'h0;
      next_st.valid = 1'h0;
      next_st.fault = 1'h0;
      next_st.donePrev = st.in2[10];
      if (!enable) begin
         next_st.div  = 16'h0000;
         next_st.busy = 1'h0;
      end else begin
         next_st.div = tick ? 16'(POLL_CYC - 1) : st.div - 16'h0001;
         // Only one conversion in flight; a late tick is skipped
         if (tick && !st.busy) begin
            next_st.start = 1'h1;
            next_st.busy  = 1'h1;
            next_st.tmr   = 12'h000;
         end
         if (st.busy) begin
            if (st.in2[10] && !st.donePrev) begin
               next_st.sample = st.in2[9:0];
               next_st.valid  = 1'h1;
               next_st.busy   = 1'h0;
            end else if (st.tmr == 12'(`ADC_TMO_CYC - 1)) begin
               // Missing conversion means broken feedback path
               next_st.fault = 1'h1;
               next_st.busy  = 1'h0;
            end else begin
               next_st.tmr = st.tmr + 12'h001;
            end
         end
      end
   end

   // State register
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign convStart   = st.start;
   assign sampleValid = st.valid;
   assign sample      = st.sample;
   assign fault       = st.fault;

endmodule

// >>> design/cart_ctl_pkg.sv
// Types for the cart position command controller
package cart_ctl_pkg;

   typedef enum logic [1:0] {AH_IDLE = 2'h0, AH_READY = 2'h1, AH_ACCEPT = 2'h2} ahState_t;
   typedef enum logic [1:0] {SH_IDLE = 2'h0, SH_SETTLE = 2'h1, SH_WAIT = 2'h2} shState_t;
   typedef enum logic [1:0] {P_KEY = 2'h0, P_SEP = 2'h1, P_NUM = 2'h2, P_BAD = 2'h3} parse_t;
   typedef enum logic {M_IDLE = 1'h0, M_RUN = 1'h1} motion_t;

   typedef struct packed {
      logic [13:0] pin1;
      logic [13:0] pin2;
      ahState_t    ah;
      logic        lsn;
      logic        tal;
      logic [7:0]  db;
      logic        dbEoi;
      logic        dbAtn;
      logic        got;
      parse_t      pst;
      logic [1:0]  cnt;
      logic [11:0] acc;
      logic        nd;
      logic        errValid;
      logic [7:0]  errCode;
      motion_t     mst;
      logic [11:0] target;
      logic [11:0] dac;
      shState_t    sh;
      logic [7:0]  dout;
      logic [5:0]  tmr;
      logic        sent;
   } ctl_state_t;

   typedef struct packed {
      logic [10:0] in1;
      logic [10:0] in2;
      logic        donePrev;
      logic [15:0] div;
      logic        busy;
      logic [11:0] tmr;
      logic        start;
      logic        valid;
      logic        fault;
      logic [9:0]  sample;
   } poll_state_t;

endpackage

// >>> design/cart_ctl_regs.svh
// Constants for the cart position command controller
`ifndef CART_CTL_REGS_SVH
`define CART_CTL_REGS_SVH

// Clock rate and bus address
`define CLK_MHZ        25
`define GPIB_ADDR      5'h04
`define CMD_MLA        (8'h20 | {3'h0, `GPIB_ADDR})
`define CMD_MTA        (8'h40 | {3'h0, `GPIB_ADDR})
`define CMD_UNL        8'h3F

// Command characters
`define KEY_CH0        8'h4D
`define KEY_CH1        8'h4F
`define KEY_CH2        8'h56
`define CH_SEMI        8'h3B
`define CH_LF          8'h0A
`define CH_CR          8'h0D
`define CH_ZERO        8'h30
`define CH_NINE        8'h39

// Destination safety limits, inclusive (300 and 965)
`define DEST_MIN       12'h12C
`define DEST_MAX       12'h3C5
`define ACC_SAT        12'hFFF

// Error bytes
`define ERR_KEY        8'h00
`define ERR_DEST       8'h01
`define ERR_SRC        8'h02
`define ERR_NONE       8'hFF

// Converter codes: 0 is +10 V, 0xFFF is -10 V
`define DAC_STOP       12'h800
`define DAC_UP         12'h600
`define DAC_DOWN       12'hA00

// Timing: bus data settling, ADC poll period and conversion timeout
`define SETTLE_NS      2000
`define SETTLE_CYC     ((`SETTLE_NS * `CLK_MHZ + 999) / 1000)
`define POLL_US        1000
`define POLL_CYC       (`POLL_US * `CLK_MHZ)
`define ADC_TMO_US     100
`define ADC_TMO_CYC    (`ADC_TMO_US * `CLK_MHZ)

`endif

// >>> design/cart_position_command_controller.sv
// Cart positioning controller driven by move commands over an IEEE 488 bus
`timescale 1ns/1ns
`include "cart_ctl_regs.svh"

// Summary of operation
// - The block listens and talks on the bus only at its one fixed address.
// - A command is the move keyword, a semicolon, then the destination digits.
// - The digits after the semicolon form a decimal target ADC reading.
// - A valid command drives the DAC so the cart heads toward the target.
// - During travel the position display voltage is sampled through the ADC.
// - The ADC is polled repeatedly until the destination is reached.
// - The cart stops as soon as the reading matches the target.
// - The DAC code is a signed velocity: sign picks direction, size picks speed.
// - A bad keyword or operand leaves an error byte the host can read back.
// - Error code zero means the first three characters were not the keyword.
// - Error code one means a missing semicolon, a bad or missing number, or a target outside 300 to 965.
// - Error code two means the ADC position feedback has failed.
module cart_position_command_controller #(
   parameter int POLL_CYC = `POLL_CYC
) (
   input  wire logic        ref_clk,
   input  wire logic        reset,
   input  wire logic [7:0]  dioIn_n,
   output logic      [7:0]  dioOut_n,
   output logic      [7:0]  dioOe,
   input  wire logic        davIn_n,
   output logic             davOut_n,
   output logic             davOe,
   input  wire logic        nrfdIn_n,
   output logic             nrfdOut_n,
   output logic             nrfdOe,
   input  wire logic        ndacIn_n,
   output logic             ndacOut_n,
   output logic             ndacOe,
   input  wire logic        eoiIn_n,
   output logic             eoiOut_n,
   output logic             eoiOe,
   input  wire logic        atn_n,
   input  wire logic        ifc_n,
   output logic             adcStart,
   input  wire logic        adcDone,
   input  wire logic [9:0]  adcData,
   output logic      [11:0] dacCode
);

   cart_ctl_pkg::ctl_state_t st;
   cart_ctl_pkg::ctl_state_t next_st;

   logic [7:0] dio;
   logic       ifc;
   logic       atn;
   logic       eoi;
   logic       dav;
   logic       nrfd;
   logic       ndac;
   logic       sampleValid;
   logic [9:0] sample;
   logic       fault;
   logic       moving;

   // Bus lines are active low; use synchronised copies, true-high
   assign ifc  = ~st.pin2[13];
   assign atn  = ~st.pin2[12];
   assign eoi  = ~st.pin2[11];
   assign dav  = ~st.pin2[10];
   assign nrfd = ~st.pin2[9];
   assign ndac = ~st.pin2[8];
   assign dio  = ~st.pin2[7:0];
   assign moving = (st.mst == cart_ctl_pkg::M_RUN);

   // Position sampling only runs while the cart travels
   adc_poller #(
      .POLL_CYC    (POLL_CYC)
   ) u_poller (
      .ref_clk     (ref_clk),
      .reset       (reset),
      .enable      (moving),
      .adcDone     (adcDone),
      .adcData     (adcData),
      .convStart   (adcStart),
      .sampleValid (sampleValid),
      .sample      (sample),
      .fault       (fault)
   );

   always_comb begin
      logic [15:0] prod;
      logic [7:0]  want;
      logic        isDigit;
      prod    = 16'h0000;
      want    = 8'h00;
      isDigit = 1'h0;
      next_st      = st;
      next_st.pin1 = {ifc_n, atn_n, eoiIn_n, davIn_n, nrfdIn_n, ndacIn_n, dioIn_n};
      next_st.pin2 = st.pin1;
      next_st.got  = 1'h0;

      // Acceptor handshake: every device takes commands under ATN
      unique case (st.ah)
         cart_ctl_pkg::AH_IDLE: begin
            if (atn || st.lsn) begin
               next_st.ah = cart_ctl_pkg::AH_READY;
            end
         end
         cart_ctl_pkg::AH_READY: begin
            if (!(atn || st.lsn)) begin
               next_st.ah = cart_ctl_pkg::AH_IDLE;
            end else if (dav) begin
               next_st.db    = dio;
               next_st.dbEoi = eoi;
               next_st.dbAtn = atn;
               next_st.got   = 1'h1;
               next_st.ah    = cart_ctl_pkg::AH_ACCEPT;
            end
         end
         cart_ctl_pkg::AH_ACCEPT: begin
            if (!dav) begin
               next_st.ah = cart_ctl_pkg::AH_READY;
            end
         end
         default: next_st.ah = cart_ctl_pkg::AH_IDLE;
      endcase

      // Source handshake: one byte with EOI per talk addressing
      unique case (st.sh)
         cart_ctl_pkg::SH_IDLE: begin
            if (st.tal && !atn && !st.sent) begin
               next_st.dout = st.errValid ? st.errCode : `ERR_NONE;
               next_st.tmr  = 6'h00;
               next_st.sh   = cart_ctl_pkg::SH_SETTLE;
            end
         end
         cart_ctl_pkg::SH_SETTLE: begin
            // Open-collector lines need time to settle before DAV
            if (atn || !st.tal) begin
               next_st.sh = cart_ctl_pkg::SH_IDLE;
            end else if (st.tmr != 6'(`SETTLE_CYC - 1)) begin
               next_st.tmr = st.tmr + 6'h01;
            end else if (!nrfd) begin
               next_st.sh = cart_ctl_pkg::SH_WAIT;
            end
         end
         cart_ctl_pkg::SH_WAIT: begin
            if (atn || !st.tal) begin
               next_st.sh = cart_ctl_pkg::SH_IDLE;
            end else if (!ndac) begin
               next_st.sh       = cart_ctl_pkg::SH_IDLE;
               next_st.sent     = 1'h1;
               next_st.errValid = 1'h0;
            end
         end
         default: next_st.sh = cart_ctl_pkg::SH_IDLE;
      endcase
      if (!st.tal || atn) begin
         next_st.sent = 1'h0;
      end

      // Travel: steer by each fresh sample, stop on arrival or overshoot
      if (moving) begin
         if (fault) begin
            next_st.mst      = cart_ctl_pkg::M_IDLE;
            next_st.dac      = `DAC_STOP;
            next_st.errValid = 1'h1;
            next_st.errCode  = `ERR_SRC;
         end else if (sampleValid) begin
            if (({2'h0, sample} == st.target) ||
                (st.dac == `DAC_UP && {2'h0, sample} > st.target) ||
                (st.dac == `DAC_DOWN && {2'h0, sample} < st.target)) begin
               next_st.mst = cart_ctl_pkg::M_IDLE;
               next_st.dac = `DAC_STOP;
            end else if ({2'h0, sample} < st.target) begin
               next_st.dac = `DAC_UP;
            end else begin
               next_st.dac = `DAC_DOWN;
            end
         end
      end

      // Bus commands under ATN set or clear our addressing
      if (st.got && st.dbAtn) begin
         if ((st.db & 8'h7F) == `CMD_MLA) begin
            next_st.lsn = 1'h1;
         end else if ((st.db & 8'h7F) == `CMD_UNL) begin
            next_st.lsn = 1'h0;
         end
         if ((st.db & 8'h7F) == `CMD_MTA) begin
            next_st.tal = 1'h1;
         end else if (st.db[6:5] == 2'h2) begin
            next_st.tal = 1'h0;
         end
      end else if (st.got && st.lsn) begin
         // First character of a command drops any old error and motion
         if (st.pst == cart_ctl_pkg::P_KEY && st.cnt == 2'h0) begin
            next_st.errValid = 1'h0;
            next_st.mst      = cart_ctl_pkg::M_IDLE;
            next_st.dac      = `DAC_STOP;
         end
         isDigit = (st.db >= `CH_ZERO) && (st.db <= `CH_NINE);
         want = (st.cnt == 2'h0) ? `KEY_CH0 : (st.cnt == 2'h1) ? `KEY_CH1 : `KEY_CH2;
         unique case (st.pst)
            cart_ctl_pkg::P_KEY: begin
               if (st.db != want) begin
                  next_st.pst      = cart_ctl_pkg::P_BAD;
                  next_st.errValid = 1'h1;
                  next_st.errCode  = `ERR_KEY;
               end else if (st.cnt == 2'h2) begin
                  next_st.pst = cart_ctl_pkg::P_SEP;
               end else begin
                  next_st.cnt = st.cnt + 2'h1;
               end
            end
            cart_ctl_pkg::P_SEP: begin
               if (st.db == `CH_SEMI) begin
                  next_st.pst = cart_ctl_pkg::P_NUM;
                  next_st.acc = 12'h000;
                  next_st.nd  = 1'h0;
               end else begin
                  next_st.pst      = cart_ctl_pkg::P_BAD;
                  next_st.errValid = 1'h1;
                  next_st.errCode  = `ERR_DEST;
               end
            end
            cart_ctl_pkg::P_NUM: begin
               if (isDigit) begin
                  // Saturate so an overlong number still fails the limit test
                  prod = {4'h0, st.acc} * 16'h000A + {8'h00, st.db - `CH_ZERO};
                  next_st.acc = (prod > 16'h0FFF) ? `ACC_SAT : prod[11:0];
                  next_st.nd  = 1'h1;
               end else if (st.db != `CH_LF && st.db != `CH_CR) begin
                  next_st.pst      = cart_ctl_pkg::P_BAD;
                  next_st.errValid = 1'h1;
                  next_st.errCode  = `ERR_DEST;
               end
            end
            cart_ctl_pkg::P_BAD: begin
               next_st.pst = cart_ctl_pkg::P_BAD; // Rest of the string ignored
            end
         endcase

         // End of string: EOI on the last byte, or a line feed
         if (st.dbEoi || st.db == `CH_LF) begin
            unique case (next_st.pst)
               cart_ctl_pkg::P_KEY: begin
                  next_st.errValid = 1'h1;
                  next_st.errCode  = `ERR_KEY;
               end
               cart_ctl_pkg::P_SEP: begin
                  next_st.errValid = 1'h1;
                  next_st.errCode  = `ERR_DEST;
               end
               cart_ctl_pkg::P_NUM: begin
                  if (!next_st.nd || next_st.acc < `DEST_MIN ||
                      next_st.acc > `DEST_MAX) begin
                     next_st.errValid = 1'h1;
                     next_st.errCode  = `ERR_DEST;
                  end else begin
                     next_st.target = next_st.acc;
                     next_st.mst    = cart_ctl_pkg::M_RUN;
                  end
               end
               cart_ctl_pkg::P_BAD: begin
                  next_st.pst = cart_ctl_pkg::P_BAD;
               end
            endcase
            next_st.pst = cart_ctl_pkg::P_KEY;
            next_st.cnt = 2'h0;
         end
      end

      // Interface clear drops addressing and both handshakes
      if (ifc) begin
         next_st.lsn = 1'h0;
         next_st.tal = 1'h0;
         next_st.ah  = cart_ctl_pkg::AH_IDLE;
         next_st.sh  = cart_ctl_pkg::SH_IDLE;
         next_st.pst = cart_ctl_pkg::P_KEY;
         next_st.cnt = 2'h0;
      end
   end

   // State register; the velocity output resets to standstill, not 0
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         st      <= '0;
         st.dac  <= `DAC_STOP;
         // Syncs start released, else a false IFC and ATN follow reset
         st.pin1 <= '1;
         st.pin2 <= '1;
      end else begin
         st <= next_st;
      end
   end

   // Open-drain drivers: enable pulls the wire low
   assign nrfdOut_n = 1'h0;
   assign ndacOut_n = 1'h0;
   assign davOut_n  = 1'h0;
   assign eoiOut_n  = 1'h0;
   assign dioOut_n  = 8'h00;
   assign nrfdOe    = (st.ah == cart_ctl_pkg::AH_ACCEPT);
   assign ndacOe    = (st.ah == cart_ctl_pkg::AH_READY);
   assign davOe     = (st.sh == cart_ctl_pkg::SH_WAIT);
   assign eoiOe     = (st.sh != cart_ctl_pkg::SH_IDLE);
   assign dioOe     = (st.sh != cart_ctl_pkg::SH_IDLE) ? st.dout : 8'h00;
   assign dacCode   = st.dac;

endmodule

// >>> verif/cart_ctl_props.sv
// Port-level concurrent checks for the cart controller
`timescale 1ns/1ns
`include "cart_ctl_regs.svh"

module cart_ctl_props #(
   parameter int POLL_CYC = 40
) (
   input wire logic        ref_clk,
   input wire logic        reset,
   input wire logic        davIn_n,
   input wire logic        nrfdIn_n,
   input wire logic        atn_n,
   input wire logic [7:0]  dioOe,
   input wire logic        davOe,
   input wire logic        nrfdOe,
   input wire logic        ndacOe,
   input wire logic        eoiOe,
   input wire logic        adcStart,
   input wire logic        adcDone,
   input wire logic [11:0] dacCode
);
   // Poll spacing plus conversion and sync slack
   localparam int POLL_LIM = POLL_CYC + 20;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);

   // Velocity codes and polling
   property p_dacLegal;
      dacCode inside {`DAC_STOP, `DAC_UP, `DAC_DOWN};
   endproperty
   a_dacLegal: assert property (p_dacLegal) else $error("dac code outside set");

   property p_startPulse;
      adcStart |=> !adcStart;
   endproperty
   a_startPulse: assert property (p_startPulse) else $error("start too long");

   property p_pollMoving;
      dacCode != `DAC_STOP |-> ##[0:POLL_LIM] (adcStart || dacCode == `DAC_STOP);
   endproperty
   a_pollMoving: assert property (p_pollMoving) else $error("no poll in travel");

   // A new direction only ever follows a finished conversion
   property p_dacAfterSample;
      $changed(dacCode) && dacCode != `DAC_STOP |-> $past(adcDone);
   endproperty
   a_dacAfterSample: assert property (p_dacAfterSample) else $error("dac without sample");

   // Acceptor handshake
   property p_takeAnswer;
      $rose(nrfdOe) |-> !ndacOe && !$past(davIn_n);
   endproperty
   a_takeAnswer: assert property (p_takeAnswer) else $error("bad accept");

   property p_rearm;
      $rose(ndacOe) |-> $past(davIn_n);
   endproperty
   a_rearm: assert property (p_rearm) else $error("rearm before release");

   // Source handshake for the one error byte
   property p_settle;
      $rose(eoiOe) |=> !davOe [*8];
   endproperty
   a_settle: assert property (p_settle) else $error("valid before settle");

   property p_talkHold;
      davOe |-> eoiOe && $stable(dioOe);
   endproperty
   a_talkHold: assert property (p_talkHold) else $error("byte moved under valid");

   property p_davReady;
      $rose(davOe) |-> $past(nrfdIn_n, 3);
   endproperty
   a_davReady: assert property (p_davReady) else $error("valid while not ready");

   property p_atnQuiet;
      !atn_n [*4] |-> !davOe && dioOe == 8'h00;
   endproperty
   a_atnQuiet: assert property (p_atnQuiet) else $error("talking under attention");

   c_up: cover property (dacCode == `DAC_UP);
   c_down: cover property (dacCode == `DAC_DOWN);
   c_talk: cover property ($rose(davOe));
   c_take: cover property ($rose(nrfdOe));
endmodule

bind cart_position_command_controller cart_ctl_props #(.POLL_CYC(POLL_CYC)) props (
   .ref_clk(ref_clk), .reset(reset), .davIn_n(davIn_n), .nrfdIn_n(nrfdIn_n),
   .atn_n(atn_n), .dioOe(dioOe), .davOe(davOe), .nrfdOe(nrfdOe), .ndacOe(ndacOe),
   .eoiOe(eoiOe), .adcStart(adcStart), .adcDone(adcDone), .dacCode(dacCode));

// >>> verif/cart_position_command_controller_tb.sv
// Self-checking bench for the cart position command controller
`timescale 1ns/1ns
`include "cart_ctl_regs.svh"

module cart_position_command_controller_tb;
   localparam int POLL = 40;
   logic        ref_clk = 1'b0;
   logic        reset = 1'b1;
   logic        adcDone = 1'b0;
   logic [9:0]  adcData = 10'h000;
   logic        adcMute = 1'b0;
   int          adcWait = 0;
   int          pos = 500;
   int          startCount = 0;
   int          err_count = 0;
   int          n_checks = 0;
   int          hostTmo;
   logic [7:0]  hDio_n;
   logic        hDav_n, hNrfd_n, hNdac_n, hEoi_n, hAtn_n, hIfc_n;
   logic [7:0]  dioOe;
   logic        davOe, nrfdOe, ndacOe, eoiOe, adcStart;
   logic [7:0]  dioOut_n;
   logic        davOut_n, nrfdOut_n, ndacOut_n, eoiOut_n;
   logic [11:0] dacCode;
   // Open-drain wires: an enabled driver shows its output level
   wire  [7:0]  dioW = hDio_n & (dioOut_n | ~dioOe);
   wire         davW = hDav_n & (davOut_n | ~davOe);
   wire         nrfdW = hNrfd_n & (nrfdOut_n | ~nrfdOe);
   wire         ndacW = hNdac_n & (ndacOut_n | ~ndacOe);
   wire         eoiW = hEoi_n & (eoiOut_n | ~eoiOe);

   always #20 ref_clk = ~ref_clk;

   cart_position_command_controller #(.POLL_CYC(POLL)) dut (
      .ref_clk(ref_clk), .reset(reset), .dioIn_n(dioW), .dioOut_n(dioOut_n), .dioOe(dioOe),
      .davIn_n(davW), .davOut_n(davOut_n), .davOe(davOe), .nrfdIn_n(nrfdW),
      .nrfdOut_n(nrfdOut_n), .nrfdOe(nrfdOe), .ndacIn_n(ndacW), .ndacOut_n(ndacOut_n),
      .ndacOe(ndacOe), .eoiIn_n(eoiW), .eoiOut_n(eoiOut_n), .eoiOe(eoiOe), .atn_n(hAtn_n),
      .ifc_n(hIfc_n), .adcStart(adcStart), .adcDone(adcDone), .adcData(adcData),
      .dacCode(dacCode));

   gpib_host_model host (
      .ref_clk(ref_clk), .dio_n(dioW), .dav_n(davW), .nrfd_n(nrfdW), .ndac_n(ndacW),
      .hDio_n(hDio_n), .hDav_n(hDav_n), .hNrfd_n(hNrfd_n), .hNdac_n(hNdac_n),
      .hEoi_n(hEoi_n), .hAtn_n(hAtn_n), .hIfc_n(hIfc_n), .tmoCount(hostTmo));

   // ADC on the display: one step of travel per conversion, data before done
   always @(posedge ref_clk) begin
      if (adcStart === 1'b1) begin
         adcDone <= 1'b0;
         adcWait <= 6;
         startCount <= startCount + 1;
      end else if (adcWait > 0) begin
         adcWait <= adcWait - 1;
         if (adcWait == 3) begin
            if (dacCode === `DAC_UP)
               pos = pos + 1;
            if (dacCode === `DAC_DOWN)
               pos = pos - 1;
            adcData <= pos[9:0];
         end
         if (adcWait == 1)
            adcDone <= !adcMute;
      end
   end

   task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   function automatic string cmdStr(input logic [7:0] third, input string rest);
      return $sformatf("%c%c%c%s", `KEY_CH0, `KEY_CH1, third, rest);
   endfunction

   // Listen address, characters with end mark on the last, then unlisten
   task automatic command(input logic [7:0] la, input string s);
      host.setAtn(1'b0);
      host.sendByte(la, 1'b0);
      host.setAtn(1'b1);
      for (int i = 0; i < s.len(); i++)
         host.sendByte(s[i], i == s.len() - 1);
      host.setAtn(1'b0);
      host.sendByte(`CMD_UNL, 1'b0);
   endtask

   task automatic readErr(input logic [7:0] exp);
      logic [7:0] b;
      host.setAtn(1'b0);
      host.sendByte(`CMD_MTA, 1'b0);
      host.setAtn(1'b1);
      host.readByte(b);
      check("errByte", {4'h0, exp}, {4'h0, b});
      host.setAtn(1'b0);
      host.sendByte(8'h5F, 1'b0);
   endtask

   task automatic waitDac(input logic [11:0] code);
      int n;
      n = 0;
      while (dacCode !== code && n < 20000) begin
         @(posedge ref_clk);
         n++;
      end
   endtask

   task automatic t_unaddressed();
      command(8'h25, cmdStr(`KEY_CH2, ";600"));
      check("idleStarts", 12'h000, 12'(startCount));
      check("idleDac", `DAC_STOP, dacCode);
      readErr(`ERR_NONE);
   endtask

   // Interface clear mid-command drops listening, so the rest is ignored
   task automatic t_ifc();
      int starts;
      string s;
      starts = startCount;
      s = ";600";
      host.setAtn(1'b0);
      host.sendByte(`CMD_MLA, 1'b0);
      host.setAtn(1'b1);
      host.sendByte(`KEY_CH0, 1'b0);
      host.sendByte(`KEY_CH1, 1'b0);
      host.sendByte(`KEY_CH2, 1'b0);
      host.pulseIfc();
      for (int i = 0; i < s.len(); i++)
         host.sendByte(s[i], i == s.len() - 1);
      repeat (20) @(posedge ref_clk);
      check("ifcStarts", 12'(starts), 12'(startCount));
      check("ifcDac", `DAC_STOP, dacCode);
      readErr(`ERR_NONE);
   endtask

   task automatic t_move(input int from, input int to, input logic [11:0] dir);
      pos <= from;
      command(`CMD_MLA, cmdStr(`KEY_CH2, $sformatf(";%0d", to)));
      waitDac(dir);
      check("dirCode", dir, dacCode);
      waitDac(`DAC_STOP);
      check("stopPos", 12'(to), 12'(pos));
      readErr(`ERR_NONE);
   endtask

   task automatic t_errors();
      string cmds[6];
      logic [7:0] codes[6] = '{`ERR_KEY, `ERR_KEY, `ERR_DEST, `ERR_DEST, `ERR_DEST, `ERR_DEST};
      cmds = '{cmdStr(8'h58, ";500"), "MO", cmdStr(`KEY_CH2, "500"),
               cmdStr(`KEY_CH2, ";966"), cmdStr(`KEY_CH2, ";299"), cmdStr(`KEY_CH2, ";5A0")};
      pos <= 350;
      command(`CMD_MLA, cmdStr(`KEY_CH2, ";900"));
      waitDac(`DAC_UP);
      command(`CMD_MLA, cmdStr(8'h58, ""));
      check("abortDac", `DAC_STOP, dacCode);
      readErr(`ERR_KEY);
      foreach (cmds[i]) begin
         command(`CMD_MLA, cmds[i]);
         check("errDac", `DAC_STOP, dacCode);
         readErr(codes[i]);
      end
      readErr(`ERR_NONE);
   endtask

   // Silent converter: the wait is the block's own conversion timeout plus 200 cycles
   task automatic t_adcFault();
      adcMute <= 1'b1;
      pos <= 500;
      command(`CMD_MLA, cmdStr(`KEY_CH2, ";700"));
      repeat (`ADC_TMO_CYC + 200) @(posedge ref_clk);
      check("faultDac", `DAC_STOP, dacCode);
      readErr(`ERR_SRC);
      adcMute <= 1'b0;
   endtask

   task automatic give_verdict();
      if (err_count == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Whole run needs about 12000 cycles; over six times that means a hang
   initial begin
      repeat (80000) @(posedge ref_clk);
      err_count++;
      give_verdict();
   end

   initial begin
      repeat (12) @(posedge ref_clk);
      reset <= 1'b0;
      repeat (2) @(posedge ref_clk);
      t_unaddressed();
      t_ifc();
      t_move(350, 400, `DAC_UP);
      t_move(420, 300, `DAC_DOWN);
      t_move(960, 965, `DAC_UP);
      t_errors();
      t_adcFault();
      check("hostTmo", 12'h000, 12'(hostTmo));
      give_verdict();
   end
endmodule

// >>> verif/gpib_host_model.sv
// Host bus controller model: open-drain source and acceptor
`timescale 1ns/1ns

module gpib_host_model (
   input  wire logic [7:0] dio_n,
   input  wire logic       ref_clk,
   input  wire logic       dav_n,
   input  wire logic       nrfd_n,
   input  wire logic       ndac_n,
   output logic      [7:0] hDio_n,
   output logic            hDav_n,
   output logic            hNrfd_n,
   output logic            hNdac_n,
   output logic            hEoi_n,
   output logic            hAtn_n,
   output logic            hIfc_n,
   output int              tmoCount
);
   wire [2:0] lines = {dav_n, ndac_n, nrfd_n};

   // Released lines float high through the pull-ups
   initial begin
      hDio_n = 8'hFF;
      hDav_n = 1'b1;
      hNrfd_n = 1'b1;
      hNdac_n = 1'b1;
      hEoi_n = 1'b1;
      hAtn_n = 1'b1;
      hIfc_n = 1'b1;
      tmoCount = 0;
   end

   // Bounded wait on a handshake line, sampled at the edge
   task automatic waitLine(input int sel, input logic v);
      int n;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (lines[sel] !== v && n < 400);
      if (n >= 400)
         tmoCount++;
   endtask

   // Extra edges let the block see attention through its syncs
   task automatic setAtn(input logic level);
      @(posedge ref_clk);
      hAtn_n <= level;
      repeat (4) @(posedge ref_clk);
   endtask

   // Interface clear held long enough to pass the block's syncs
   task automatic pulseIfc();
      @(posedge ref_clk);
      hIfc_n <= 1'b0;
      repeat (4) @(posedge ref_clk);
      hIfc_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
   endtask

   task automatic sendByte(input logic [7:0] b, input logic eoi);
      waitLine(0, 1'b1);
      hDio_n <= ~b;
      hEoi_n <= ~eoi;
      repeat (2) @(posedge ref_clk);
      hDav_n <= 1'b0;
      waitLine(1, 1'b1);
      hDav_n <= 1'b1;
      hDio_n <= 8'hFF;
      hEoi_n <= 1'b1;
   endtask

   task automatic readByte(output logic [7:0] b);
      @(posedge ref_clk);
      hNdac_n <= 1'b0;
      waitLine(2, 1'b0);
      b = ~dio_n;
      hNrfd_n <= 1'b0;
      hNdac_n <= 1'b1;
      waitLine(2, 1'b1);
      hNrfd_n <= 1'b1;
   endtask
endmodule
